// ---- logic/ats_defs.svh ----
// Timing counts, sizes and field widths of the teach-in sequencer
`ifndef ATS_DEFS_SVH
`define ATS_DEFS_SVH

`define ATS_CODE_W          16
`define ATS_DEACT_DEPTH     3
`define ATS_SEC_W           11

`define ATS_CLK_PERIOD_NS   8
`define ATS_EIGHTH_NS       125000000
`define ATS_EIGHTH_CYC      (`ATS_EIGHTH_NS / `ATS_CLK_PERIOD_NS)
`define ATS_PHASE_LAST      3'h7

`define ATS_TEACH_WIN_MIN   30
`define ATS_REPL_WIN_MIN    5
`define ATS_CONFIRM_MIN     5
`define ATS_LOCK_RETRY_MIN  10
`define ATS_DWELL_S         3
`define ATS_POWER_OFF_S     3
`define ATS_START_SEQ_S     2
`define ATS_TEACH_S         1
`define ATS_SEC_PER_MIN     60

`endif

// ---- logic/ats_pkg.sv ----
// Types shared by the teach-in sequencer modules
`include "ats_defs.svh"

package ats_pkg;

  typedef logic [`ATS_CODE_W-1:0] ats_code_t;
  typedef logic [`ATS_SEC_W-1:0]  ats_sec_t;

  typedef enum logic [2:0] {
    ST_START    = 3'h0,
    ST_WAIT     = 3'h1,
    ST_DWELL    = 3'h2,
    ST_TEACHING = 3'h3,
    ST_TAUGHT   = 3'h4,
    ST_RUN      = 3'h5,
    ST_SAFE     = 3'h6
  } ats_state_t;

  typedef enum logic [2:0] {
    CAUSE_NONE       = 3'h0,
    CAUSE_TEACH_WIN  = 3'h1,
    CAUSE_CONFIRM_TO = 3'h2,
    CAUSE_REMOVED    = 3'h3,
    CAUSE_DEACT      = 3'h4,
    CAUSE_LOCK_TO    = 3'h5
  } ats_cause_t;

endpackage

// ---- logic/ats_sequencer.sv ----
// Teach-in and safety output sequencer of a coded locking switch
`timescale 1ns/1ns
`include "ats_defs.svh"

module ats_sequencer #(
  parameter int unsigned EIGHTH_CYC = `ATS_EIGHTH_CYC
) (
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RESET,
  input  wire logic              I_FACTORY_CLEAR,
  input  wire logic              I_UNIVERSAL,
  input  wire logic              I_ACT_PRESENT,
  input  wire ats_pkg::ats_code_t I_ACT_CODE,
  input  wire logic              I_LOCK_IN,
  input  wire logic              I_POWER_TO_RELEASE,
  input  wire logic              I_LOCK_ENGAGED,
  output logic                   O_SAFETY_OUTPUT_FIRST,
  output logic                   O_SAFETY_OUTPUT_SECOND,
  output logic                   O_LOCK_DRIVE,
  output logic                   O_PRESENCE_RED,
  output logic                   O_PRESENCE_GREEN,
  output logic                   O_LOCKING_GREEN,
  output logic                   O_DIAG_YELLOW,
  output logic                   O_DIAG_RED,
  output ats_pkg::ats_cause_t    O_FAULT_CAUSE
);
  import ats_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  ats_tick_if tk ();

  ats_state_t st_ff;
  ats_state_t nxt_st;
  ats_cause_t cause_ff;
  ats_cause_t nxt_cause;
  ats_sec_t   uptime_ff;
  ats_sec_t   cnt_ff;
  ats_sec_t   lock_cnt_ff;
  logic       boot_ff;

  // Survives power cycles; cleared only by factory clear, except pend_valid_ff, also cleared on promotion and in ST_SAFE
  ats_code_t  cur_code_ff;
  logic       cur_valid_ff;
  ats_code_t  pend_code_ff;
  logic       pend_valid_ff;
  ats_code_t  deact_mem [`ATS_DEACT_DEPTH];
  logic       deact_vld [`ATS_DEACT_DEPTH];

  logic       ossd1_ff;
  logic       ossd2_ff;
  logic       lock_drv_ff;
  logic       p_red_ff;
  logic       p_grn_ff;
  logic       l_grn_ff;
  logic       d_yel_ff;
  logic       d_red_ff;

  logic       act_ok;
  logic       is_cur;
  logic       is_deact;
  logic       lock_want;
  logic       lock_stall;
  logic       promote;
  logic       commit;
  logic       f4;
  logic       f2;
  logic       f1;

  function automatic ats_sec_t sec_of(input int unsigned minutes);
    return ats_sec_t'(minutes * `ATS_SEC_PER_MIN);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Slow tick

  ats_tick_gen #(
    .EIGHTH_CYC (EIGHTH_CYC)
  ) u_tick (
    .i_clk (I_SYS_CLK),
    .i_rst (I_RESET),
    .tk    (tk.src)
  );

  assign f4 = tk.phase[0];
  assign f2 = tk.phase[1];
  assign f1 = tk.phase[2];

  ////////////////////////////////////////////////////////////////////////
  // Code matching

  always_comb begin
    is_deact = 1'b0;
    for (int i = 0; i < `ATS_DEACT_DEPTH; i++) begin
      if (deact_vld[i] && (deact_mem[i] == I_ACT_CODE)) begin
        is_deact = 1'b1;
      end
    end
  end

  assign is_cur     = cur_valid_ff && (I_ACT_CODE == cur_code_ff);
  assign act_ok     = I_ACT_PRESENT && (I_UNIVERSAL || is_cur);
  assign lock_want  = I_LOCK_IN ^ I_POWER_TO_RELEASE;
  assign lock_stall = lock_want && act_ok && !I_LOCK_ENGAGED;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    nxt_st    = st_ff;
    nxt_cause = cause_ff;
    case (st_ff)
      ST_START: begin
        if (cnt_ff >= ats_sec_t'(`ATS_START_SEQ_S)) begin
          nxt_st = I_UNIVERSAL ? ST_RUN : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cur_valid_ff) begin
          if (uptime_ff >= sec_of(`ATS_REPL_WIN_MIN)) begin
            nxt_st = ST_RUN;
          end else if (I_ACT_PRESENT && is_cur) begin
            nxt_st = ST_RUN;
          end else if (I_ACT_PRESENT && is_deact) begin
            nxt_st    = ST_SAFE;
            nxt_cause = CAUSE_DEACT;
          end else if (I_ACT_PRESENT) begin
            nxt_st = ST_DWELL;
          end
        end else if (uptime_ff >= sec_of(`ATS_TEACH_WIN_MIN)) begin
          nxt_st    = ST_SAFE;
          nxt_cause = CAUSE_TEACH_WIN;
        end else if (I_ACT_PRESENT && is_deact) begin
          nxt_st    = ST_SAFE;
          nxt_cause = CAUSE_DEACT;
        end else if (I_ACT_PRESENT) begin
          nxt_st = ST_DWELL;
        end
      end
      ST_DWELL: begin
        if (!I_ACT_PRESENT) begin
          nxt_st = ST_WAIT;
        end else if (cnt_ff >= ats_sec_t'(`ATS_DWELL_S)) begin
          nxt_st = ST_TEACHING;
        end
      end
      ST_TEACHING: begin
        if (!I_ACT_PRESENT) begin
          nxt_st    = ST_SAFE;
          nxt_cause = CAUSE_REMOVED;
        end else if (cnt_ff >= ats_sec_t'(`ATS_TEACH_S)) begin
          nxt_st = ST_TAUGHT;
        end
      end
      ST_TAUGHT: begin
        if (cnt_ff >= sec_of(`ATS_CONFIRM_MIN)) begin
          nxt_st    = ST_SAFE;
          nxt_cause = CAUSE_CONFIRM_TO;
        end
      end
      ST_RUN: begin
        if (lock_stall && (lock_cnt_ff >= sec_of(`ATS_LOCK_RETRY_MIN))) begin
          nxt_st    = ST_SAFE;
          nxt_cause = CAUSE_LOCK_TO;
        end
      end
      ST_SAFE: begin
        nxt_st = ST_SAFE;
      end
      default: begin
        nxt_st    = ST_SAFE;
        nxt_cause = cause_ff;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      st_ff    <= ST_START;
      cause_ff <= CAUSE_NONE;
    end else begin
      st_ff    <= nxt_st;
      cause_ff <= nxt_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Second counters, cleared on power-on only, per state, or whenever the lock is not stalled in ST_RUN

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      uptime_ff <= '0;
    end else if (tk.sec_tick && (uptime_ff != '1)) begin
      uptime_ff <= uptime_ff + ats_sec_t'(1);
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cnt_ff <= '0;
    end else if (nxt_st != st_ff) begin
      cnt_ff <= '0;
    end else if (tk.sec_tick && (cnt_ff != '1)) begin
      cnt_ff <= cnt_ff + ats_sec_t'(1);
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      lock_cnt_ff <= '0;
    end else if (!(lock_stall && (st_ff == ST_RUN))) begin
      lock_cnt_ff <= '0;
    end else if (tk.sec_tick && (lock_cnt_ff != '1)) begin
      lock_cnt_ff <= lock_cnt_ff + ats_sec_t'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Code memory

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
    end
  end

  assign promote = boot_ff && pend_valid_ff;
  assign commit  = (st_ff == ST_TEACHING) && (nxt_st == ST_TAUGHT);

  // Pending code becomes valid only on the next power-up
  always_ff @(posedge I_SYS_CLK) begin
    if (I_FACTORY_CLEAR) begin
      cur_valid_ff  <= 1'b0;
      pend_valid_ff <= 1'b0;
      cur_code_ff   <= '0;
      pend_code_ff  <= '0;
      for (int i = 0; i < `ATS_DEACT_DEPTH; i++) begin
        deact_mem[i] <= '0;
        deact_vld[i] <= 1'b0;
      end
    end else if (promote) begin
      cur_code_ff   <= pend_code_ff;
      cur_valid_ff  <= 1'b1;
      pend_valid_ff <= 1'b0;
      deact_mem[0]  <= cur_code_ff;
      deact_vld[0]  <= cur_valid_ff;
      for (int i = 1; i < `ATS_DEACT_DEPTH; i++) begin
        deact_mem[i] <= deact_mem[i-1];
        deact_vld[i] <= deact_vld[i-1];
      end
    end else if (commit) begin
      pend_code_ff  <= I_ACT_CODE;
      pend_valid_ff <= 1'b1;
    end else if ((st_ff == ST_SAFE) || (nxt_st == ST_SAFE)) begin
      pend_valid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and lamps

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ossd1_ff    <= 1'b0;
      ossd2_ff    <= 1'b0;
      lock_drv_ff <= 1'b0;
    end else begin
      ossd1_ff    <= (st_ff == ST_RUN) && act_ok;
      ossd2_ff    <= (st_ff == ST_RUN) && act_ok;
      lock_drv_ff <= (st_ff == ST_RUN) && lock_want && act_ok;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      p_red_ff <= 1'b0;
      p_grn_ff <= 1'b0;
      l_grn_ff <= 1'b0;
      d_yel_ff <= 1'b0;
      d_red_ff <= 1'b0;
    end else begin
      case (st_ff)
        ST_START: begin
          p_red_ff <= f2;
          p_grn_ff <= !f2;
          l_grn_ff <= f2;
          d_yel_ff <= f2;
          d_red_ff <= !f2;
        end
        ST_WAIT, ST_DWELL: begin
          p_red_ff <= 1'b1;
          p_grn_ff <= 1'b0;
          l_grn_ff <= 1'b0;
          d_yel_ff <= f4;
          d_red_ff <= !f4;
        end
        ST_TEACHING: begin
          p_red_ff <= 1'b0;
          p_grn_ff <= f4;
          l_grn_ff <= 1'b0;
          d_yel_ff <= f4;
          d_red_ff <= !f4;
        end
        ST_TAUGHT: begin
          p_red_ff <= 1'b0;
          p_grn_ff <= f4;
          l_grn_ff <= 1'b0;
          d_yel_ff <= f4;
          d_red_ff <= 1'b0;
        end
        ST_RUN: begin
          p_red_ff <= !act_ok;
          p_grn_ff <= act_ok;
          l_grn_ff <= lock_want && (I_LOCK_ENGAGED || f1);
          d_yel_ff <= 1'b0;
          d_red_ff <= 1'b0;
        end
        ST_SAFE: begin
          p_red_ff <= f4;
          p_grn_ff <= !f4;
          l_grn_ff <= 1'b0;
          d_yel_ff <= 1'b0;
          d_red_ff <= (cause_ff == CAUSE_REMOVED) ? 1'b1 : f4;
        end
        default: begin
          p_red_ff <= 1'b1;
          p_grn_ff <= 1'b0;
          l_grn_ff <= 1'b0;
          d_yel_ff <= 1'b0;
          d_red_ff <= 1'b1;
        end
      endcase
    end
  end

  assign O_SAFETY_OUTPUT_FIRST  = ossd1_ff;
  assign O_SAFETY_OUTPUT_SECOND = ossd2_ff;
  assign O_LOCK_DRIVE           = lock_drv_ff;
  assign O_PRESENCE_RED         = p_red_ff;
  assign O_PRESENCE_GREEN       = p_grn_ff;
  assign O_LOCKING_GREEN        = l_grn_ff;
  assign O_DIAG_YELLOW          = d_yel_ff;
  assign O_DIAG_RED             = d_red_ff;
  assign O_FAULT_CAUSE          = cause_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RESET);

  property p_start_off;
    (st_ff == ST_START) |-> !ossd1_ff && !ossd2_ff;
  endproperty
  a_start_off: assert property (p_start_off) else $error("outputs on in start");

  property p_two_chan;
    ossd1_ff == ossd2_ff;
  endproperty
  a_two_chan: assert property (p_two_chan) else $error("channels disagree");

  property p_run_on;
    (st_ff == ST_RUN) && act_ok && (nxt_st == ST_RUN) |=> ossd1_ff && p_grn_ff;
  endproperty
  a_run_on: assert property (p_run_on) else $error("valid actuator not enabled");

  property p_teach_win;
    (st_ff == ST_WAIT) && !cur_valid_ff && (uptime_ff >= sec_of(`ATS_TEACH_WIN_MIN))
      |=> (st_ff == ST_SAFE) && (cause_ff == CAUSE_TEACH_WIN);
  endproperty
  a_teach_win: assert property (p_teach_win) else $error("teach window not closed");

  property p_safe_stays;
    (st_ff == ST_SAFE) |=> (st_ff == ST_SAFE) [*8];
  endproperty
  a_safe_stays: assert property (p_safe_stays) else $error("safe state left");

  property p_dwell;
    (st_ff == ST_TEACHING) && ($past(st_ff) == ST_DWELL)
      |-> $past(cnt_ff) >= ats_sec_t'(`ATS_DWELL_S);
  endproperty
  a_dwell: assert property (p_dwell) else $error("teach began early");

  property p_removed;
    (st_ff == ST_TEACHING) && !I_ACT_PRESENT
      |=> (st_ff == ST_SAFE) && (cause_ff == CAUSE_REMOVED) && !pend_valid_ff;
  endproperty
  a_removed: assert property (p_removed) else $error("abort not handled");

  property p_cur_cancel;
    (st_ff == ST_WAIT) && cur_valid_ff && I_ACT_PRESENT && is_cur |=> (st_ff == ST_RUN);
  endproperty
  a_cur_cancel: assert property (p_cur_cancel) else $error("current code not cancelling");

  property p_deact;
    (st_ff == ST_WAIT) && I_ACT_PRESENT && is_deact && !is_cur
      && (uptime_ff < sec_of(`ATS_REPL_WIN_MIN))
      |=> (st_ff == ST_SAFE) && $stable(cur_code_ff);
  endproperty
  a_deact: assert property (p_deact) else $error("deactivated code accepted");

  property p_confirm;
    (st_ff == ST_TAUGHT) && (cnt_ff >= sec_of(`ATS_CONFIRM_MIN))
      |=> (st_ff == ST_SAFE) ##1 !pend_valid_ff;
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirm timeout missed");

  property p_lock_to;
    (st_ff == ST_RUN) && lock_stall && (lock_cnt_ff >= sec_of(`ATS_LOCK_RETRY_MIN))
      |=> (st_ff == ST_SAFE) && (cause_ff == CAUSE_LOCK_TO);
  endproperty
  a_lock_to: assert property (p_lock_to) else $error("lock timeout missed");

endmodule

// ---- logic/ats_tick_gen.sv ----
// Divider making eighth-second blink phase and one-second tick
`timescale 1ns/1ns
`include "ats_defs.svh"

module ats_tick_gen #(
  parameter int unsigned EIGHTH_CYC = `ATS_EIGHTH_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  ats_tick_if.src   tk
);
  import ats_pkg::*;

  logic [23:0] div_ff;
  logic [2:0]  phase_ff;
  logic        sec_ff;
  logic        wrap;

  assign wrap = (div_ff == 24'(EIGHTH_CYC - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_ff <= 24'h000000;
    end else if (wrap) begin
      div_ff <= 24'h000000;
    end else begin
      div_ff <= div_ff + 24'h000001;
    end
  end

  // Bit 0 toggles at 4 Hz, bit 1 at 2 Hz, bit 2 at 1 Hz
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_ff <= 3'h0;
      sec_ff   <= 1'b0;
    end else begin
      sec_ff <= wrap && (phase_ff == `ATS_PHASE_LAST);
      if (wrap) begin
        phase_ff <= phase_ff + 3'h1;
      end
    end
  end

  assign tk.sec_tick = sec_ff;
  assign tk.phase    = phase_ff;

endmodule

// ---- logic/ats_tick_if.sv ----
// Slow tick and blink phase carried from the divider to the sequencer
`timescale 1ns/1ns

interface ats_tick_if;
  logic       sec_tick;
  logic [2:0] phase;
  modport src (output sec_tick, output phase);
  modport dst (input sec_tick, input phase);
endinterface

// ---- testbench/ats_ctrl_model.sv ----
// Behavioural machine controller: lock request pin and lock mechanism
`timescale 1ns/1ns

module ats_ctrl_model (
  input  wire logic i_clk,
  input  wire logic i_want_lock,
  input  wire logic i_power_to_release,
  input  wire logic i_jam,
  input  wire logic i_lock_drive,
  output logic      o_lock_in,
  output logic      o_lock_engaged
);
  logic [3:0] settle_ff = 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // Pin level for a lock request depends on the variant
  assign o_lock_in = i_want_lock ^ i_power_to_release;

  ////////////////////////////////////////////////////////////////////////
  // Mechanism engages some cycles after drive, never while jammed
  always_ff @(posedge i_clk) begin
    if (!i_lock_drive || i_jam) begin
      settle_ff <= 4'h0;
    end else if (settle_ff != 4'hF) begin
      settle_ff <= settle_ff + 4'h1;
    end
  end
  assign o_lock_engaged = (settle_ff >= 4'h8);
endmodule

// ---- testbench/ats_sequencer_tb.sv ----
// Self-checking bench of the teach-in sequencer
`timescale 1ns/1ns

module ats_sequencer_tb;
  import ats_pkg::*;
  localparam int SC = 32;
  localparam int LIM = 8 * SC;
  logic      clk = 1'b0;
  logic      rst, fclr, univ, pres, ptr, want, jam;
  logic      lock_in, engaged;
  ats_code_t code;
  logic      sf1, sf2, ldrv, p_red, p_grn, l_grn, d_yel, d_red;
  ats_cause_t cause;
  int        n_errors = 0;
  int        total_checks = 0;
  int        n, i;
  logic [2:0] rows [4] = '{3'b000, 3'b011, 3'b100, 3'b111};
  ats_code_t  codes [3] = '{16'h0C0C, 16'h0D0D, 16'h0E0E};

  always #4 clk = ~clk;

  ats_sequencer #(.EIGHTH_CYC(4)) i_dut (
    .I_SYS_CLK(clk), .I_RESET(rst), .I_FACTORY_CLEAR(fclr), .I_UNIVERSAL(univ),
    .I_ACT_PRESENT(pres), .I_ACT_CODE(code), .I_LOCK_IN(lock_in), .I_POWER_TO_RELEASE(ptr),
    .I_LOCK_ENGAGED(engaged), .O_SAFETY_OUTPUT_FIRST(sf1), .O_SAFETY_OUTPUT_SECOND(sf2),
    .O_LOCK_DRIVE(ldrv), .O_PRESENCE_RED(p_red), .O_PRESENCE_GREEN(p_grn),
    .O_LOCKING_GREEN(l_grn), .O_DIAG_YELLOW(d_yel), .O_DIAG_RED(d_red), .O_FAULT_CAUSE(cause));

  ats_ctrl_model i_ctrl (
    .i_clk(clk), .i_want_lock(want), .i_power_to_release(ptr), .i_jam(jam),
    .i_lock_drive(ldrv), .o_lock_in(lock_in), .o_lock_engaged(engaged));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic sec(input int k);
    cyc(k * SC);
  endtask

  // Supply cycle; optional return to delivery condition
  task automatic pwr(input logic clr);
    rst = 1'b1;
    cyc(3 * SC);
    rst = 1'b0;
    fclr = clr;
    cyc(1);
    fclr = 1'b0;
  endtask

  task automatic wait_green(output int cnt);
    cnt = 0;
    while (p_grn !== 1'b1 && cnt < LIM) begin
      cyc(1);
      cnt++;
    end
  endtask

  task automatic teach(input ats_code_t c);
    pres = 1'b0;
    pwr(1'b0);
    sec(3);
    pres = 1'b1;
    code = c;
    wait_green(n);
    sec(3);
    pres = 1'b0;
    pwr(1'b0);
  endtask

  task automatic end_sim;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #(64'd110000 * 8);
    n_errors++;
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; fclr = 1'b0; univ = 1'b0; pres = 1'b0;
    code = 16'h0A0A; ptr = 1'b0; want = 1'b0; jam = 1'b0;
    cyc(12);
    chk({sf1, sf2, p_red, p_grn, cause}, 16'h0000);
    rst = 1'b0;
    fclr = 1'b1;
    cyc(1);
    fclr = 1'b0;
    sec(1);
    chk({sf1, sf2}, 16'h0000);
    sec(2);
    chk({p_red, p_grn, l_grn, d_yel ^ d_red}, 16'h0009);
    // First teach of code A
    pres = 1'b1;
    wait_green(n);
    chk(16'(n > 2 * SC && n <= 4 * SC + 4), 16'h0001);
    chk({p_red, l_grn, d_yel ^ d_red, sf1}, 16'h0002);
    sec(3);
    for (i = 0; i < 8; i++) begin
      chk({p_red, l_grn, d_red, sf1, sf2}, 16'h0000);
      cyc(4);
    end
    pres = 1'b0;
    pwr(1'b0);
    // Readiness closes; a new code no longer starts teaching
    sec(302);
    pres = 1'b1;
    code = 16'h0F0F;
    wait_green(n);
    chk({1'(n == LIM), sf1, sf2, cause}, 16'h0020);
    code = 16'h0A0A;
    cyc(4);
    chk({sf1, sf2, p_grn, p_red}, 16'h000E);
    for (i = 0; i < 4; i++) begin
      ptr = rows[i][2];
      want = rows[i][1];
      cyc(3);
      chk(ldrv, rows[i][0]);
    end
    ptr = 1'b0;
    want = 1'b1;
    jam = 1'b1;
    sec(598);
    chk(cause, CAUSE_NONE);
    sec(4);
    chk({sf1, sf2, cause}, {2'b00, CAUSE_LOCK_TO});
    jam = 1'b0;
    want = 1'b0;
    cyc(50);
    chk(cause, CAUSE_LOCK_TO);
    // Replacement taught but never confirmed
    pres = 1'b0;
    pwr(1'b0);
    sec(3);
    pres = 1'b1;
    code = 16'h0B0B;
    wait_green(n);
    sec(300);
    chk(cause, CAUSE_NONE);
    sec(5);
    chk({sf1, cause}, {1'b0, CAUSE_CONFIRM_TO});
    pres = 1'b0;
    pwr(1'b0);
    sec(3);
    pres = 1'b1;
    code = 16'h0A0A;
    cyc(4);
    chk({sf1, sf2, cause}, 16'h0018);
    // Confirmed replacement, then the retired code shows up
    teach(16'h0B0B);
    sec(3);
    pres = 1'b1;
    code = 16'h0A0A;
    cyc(4);
    chk({sf1, sf2, cause}, {2'b00, CAUSE_DEACT});
    // Actuator pulled during teaching
    pres = 1'b0;
    pwr(1'b0);
    sec(3);
    pres = 1'b1;
    code = 16'h0C0C;
    wait_green(n);
    cyc(8);
    pres = 1'b0;
    cyc(4);
    chk({sf1, d_red, cause}, {2'b01, CAUSE_REMOVED});
    // Three more retirements push code A out of the list
    for (i = 0; i < 3; i++) begin
      teach(codes[i]);
    end
    sec(3);
    pres = 1'b1;
    code = 16'h0A0A;
    wait_green(n);
    chk({1'(n < LIM), cause}, 16'h0008);
    // Delivery window runs out
    pres = 1'b0;
    pwr(1'b1);
    sec(1797);
    chk(cause, CAUSE_NONE);
    sec(5);
    chk({sf1, cause}, {1'b0, CAUSE_TEACH_WIN});
    pres = 1'b1;
    sec(5);
    chk({p_red ^ p_grn, d_yel, sf1, cause}, {3'b100, CAUSE_TEACH_WIN});
    pres = 1'b0;
    pwr(1'b0);
    sec(3);
    chk({p_red, cause}, 16'h0008);
    pres = 1'b1;
    wait_green(n);
    chk(16'(n < LIM), 16'h0001);
    // Universal variant needs no teaching
    univ = 1'b1;
    pres = 1'b0;
    pwr(1'b1);
    sec(3);
    pres = 1'b1;
    code = 16'h1234;
    cyc(4);
    chk({sf1, sf2}, 16'h0003);
    end_sim;
  end
endmodule
